// ==== src/asc_pkg.sv ====
// Purpose: Shared constants and types for the depth-limited scan sequencer
// Assumes: 16-bit frames, MSB first, framed by an active-low chip select
// Notes:   Field positions refer to the received frame word

package asc_pkg;

  // Frame geometry
  localparam int         FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [4:0] CNT_ONE    = 5'h01;

  // Frame command nibble codes
  localparam logic [3:0] CMD_CONTINUE = 4'h0;
  localparam logic [3:0] CMD_AUTO2    = 4'h3;
  localparam logic [3:0] CMD_DEPTH    = 4'h9;

  // Field positions in the received word
  localparam int CMD_MSB   = 15;
  localparam int CMD_LSB   = 12;
  localparam int WEN_BIT   = 11;
  localparam int CLR_BIT   = 10;
  localparam int LAST_MSB  = 9;
  localparam int LAST_LSB  = 6;
  localparam int SPAN_BIT  = 6;
  localparam int SLEEP_BIT = 5;
  localparam int FMT_BIT   = 4;
  localparam int GPIO_MSB  = 3;
  localparam int GPIO_LSB  = 0;

  // Reset values
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [3:0] LAST_RST = 4'h7;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef struct packed {
    logic       ctr_clear;
    logic       span;
    logic       sleep;
    logic       fmt;
    logic [3:0] gpio_lvl;
  } asc_cfg_t;

  localparam asc_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, GPIO_RST};

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       serial_command_in;
    logic [3:0] gpio;
  } asc_pins_t;

  localparam asc_pins_t PINS_RST = '{1'b0, 1'b1, 1'b0, GPIO_RST};

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } asc_state_t;

  typedef enum logic {
    MODE_OTHER = 1'b0,
    MODE_AUTO2 = 1'b1
  } asc_mode_t;

  // Next channel of the wrapping scan
  function automatic logic [3:0] next_channel(input logic [3:0] cur,
                                               input logic [3:0] last);
    next_channel = (cur == last) ? CHAN_RST : cur + 4'h1;
  endfunction

endpackage

// ==== src/asc_pin_sync.sv ====
// Purpose: Two-stage synchronisers and edge detection for the serial pins
// Assumes: SCLK well below a quarter of i_clk
// Notes:   Only the second stage feeds any logic

`timescale 1ns/1ps

module asc_pin_sync (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Raw pins
  input  wire asc_pkg::asc_pins_t i_pins,
  // Synchronised levels and edges
  output asc_pkg::asc_pins_t      o_pins,
  output logic                    o_sclk_rise,
  output logic                    o_sclk_fall,
  output logic                    o_cs_fall
);

  asc_pkg::asc_pins_t meta_ff;
  asc_pkg::asc_pins_t sync_ff;
  logic               sclk_d_ff;
  logic               cs_n_d_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff   <= asc_pkg::PINS_RST;
      sync_ff   <= asc_pkg::PINS_RST;
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      meta_ff   <= i_pins;
      sync_ff   <= meta_ff;
      sclk_d_ff <= sync_ff.sclk;
      cs_n_d_ff <= sync_ff.cs_n;
    end
  end

  assign o_pins      = sync_ff;
  assign o_sclk_rise = sync_ff.sclk & ~sclk_d_ff;
  assign o_sclk_fall = ~sync_ff.sclk & sclk_d_ff;
  assign o_cs_fall   = ~sync_ff.cs_n & cs_n_d_ff;

endmodule

// ==== src/asc_frame_shift.sv ====
// Purpose: 16-bit frame shifter, input sampled on rising, output on falling
// Assumes: Edge strobes come from the pin synchroniser
// Notes:   A frame cut short by chip select is dropped

`timescale 1ns/1ps

module asc_frame_shift (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Synchronised pins and edges
  input  wire logic        i_cs_n,
  input  wire logic        i_sdi,
  input  wire logic        i_sclk_rise,
  input  wire logic        i_sclk_fall,
  input  wire logic        i_cs_fall,
  // Word to send
  input  wire logic [15:0] i_tx_word,
  // Results
  output logic [15:0]      o_rx_word,
  output logic             o_done,
  output logic             o_sdo,
  output logic             o_sdo_oe
);

  asc_pkg::asc_state_t state_ff;
  asc_pkg::asc_state_t nxt_state;
  logic [15:0]         rx_ff;
  logic [15:0]         tx_ff;
  logic [4:0]          cnt_ff;
  logic [4:0]          cnt_inc;
  logic                last_fall;
  logic                in_shift;

  assign in_shift  = (state_ff == asc_pkg::ST_SHIFT);
  assign cnt_inc   = cnt_ff + asc_pkg::CNT_ONE;
  assign last_fall = in_shift & i_sclk_fall & ~i_cs_n
                     & (cnt_inc == asc_pkg::FRAME_LAST);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      asc_pkg::ST_IDLE: begin
        if (i_cs_fall) begin
          nxt_state = asc_pkg::ST_SHIFT;
        end
      end
      asc_pkg::ST_SHIFT: begin
        if (i_cs_n) begin
          nxt_state = asc_pkg::ST_IDLE;
        end else if (last_fall) begin
          nxt_state = asc_pkg::ST_DONE;
        end
      end
      asc_pkg::ST_DONE: begin
        if (i_cs_n) begin
          nxt_state = asc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = asc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= asc_pkg::ST_IDLE;
      rx_ff    <= asc_pkg::WORD_RST;
      tx_ff    <= asc_pkg::WORD_RST;
      cnt_ff   <= asc_pkg::CNT_ZERO;
      o_done   <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_done   <= last_fall;
      o_sdo_oe <= ~i_cs_n;
      if (i_cs_fall) begin
        tx_ff  <= i_tx_word;
        cnt_ff <= asc_pkg::CNT_ZERO;
      end else if (in_shift && i_sclk_fall) begin
        tx_ff  <= {tx_ff[14:0], 1'b0};
        cnt_ff <= cnt_inc;
      end
      if (in_shift && i_sclk_rise) begin
        rx_ff <= {rx_ff[14:0], i_sdi};
      end
    end
  end

  assign o_rx_word = rx_ff;
  assign o_sdo     = tx_ff[15];

endmodule

// ==== src/asc_sequencer.sv ====
// Purpose: Frame decoder and channel sequencer for depth-limited scan mode
// Assumes: Host drives 16-clock frames framed by low chip select;
//          SCLK at most one eighth of i_clk
// Notes:   Result data arrives from the converter on the same clock
//
// Function
// - Span bit picks 2.5V (0) or 5V (1); resets to 0
// - Sleep bit powers down at sixteenth falling SCLK edge
// - Format 0 sends channel address on top nibble, then 12-bit result
// - Format 1 sends GPIO3..GPIO0 on top nibble, result below
// - Low four bits set GPIO levels, only on output pins
// - Depth frame leaves span and GPIO untouched, output stays valid
// - Code 1001 programs depth; bits 11-10 and 5-0 ignored
// - Bits 9-6 of depth frame store last scan channel
// - Counter runs from zero to last channel, then wraps to zero
// - Code 0000 keeps mode and settings, ignores lower twelve bits

`timescale 1ns/1ps

module asc_sequencer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Serial pins from host
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_serial_command_in,
  output logic             o_serial_result_out,
  output logic             o_serial_result_oe,
  // GPIO pins
  input  wire logic [3:0]  i_gpio,
  output logic [3:0]       o_gpio,
  output logic [3:0]       o_gpio_oe,
  input  wire logic [3:0]  i_gpio_is_output,
  // Converter side
  input  wire logic [11:0] i_conv_result,
  output logic             o_conv_start,
  output logic [3:0]       o_conv_channel,
  output logic             o_input_span_select,
  output logic             o_sleep,
  // Status
  output logic             o_scan_mode_active,
  output logic [3:0]       o_last_channel
);

  // Synchronised pins and edges
  asc_pkg::asc_pins_t raw_pins;
  asc_pkg::asc_pins_t sync_pins;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               cs_fall;

  // Frame words
  logic [15:0]        rx_word;
  logic [15:0]        tx_word;
  logic               frame_done;

  // Held state
  asc_pkg::asc_mode_t mode_ff;
  asc_pkg::asc_cfg_t  cfg_ff;
  logic [3:0]         last_ch_ff;
  logic [3:0]         chan_ff;
  logic               sleep_ff;
  logic               conv_start_ff;
  logic [3:0]         conv_channel_ff;

  // Next values
  asc_pkg::asc_mode_t nxt_mode;
  asc_pkg::asc_cfg_t  nxt_cfg;
  logic [3:0]         nxt_last_ch;
  logic [3:0]         nxt_chan;
  logic               nxt_sleep;

  // Decoded fields
  logic [3:0]         frame_command_nibble;
  logic               lower_field_write_enable;
  asc_pkg::asc_cfg_t  rx_cfg;
  logic [3:0]         last_channel_field;
  logic               is_auto2;
  logic               is_depth;
  logic               is_continue;
  logic               cfg_write;
  logic [3:0]         top_nibble;

  assign raw_pins = '{i_sclk, i_cs_n, i_serial_command_in, i_gpio};

  asc_pin_sync u_sync (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_pins      (raw_pins),
    .o_pins      (sync_pins),
    .o_sclk_rise (sclk_rise),
    .o_sclk_fall (sclk_fall),
    .o_cs_fall   (cs_fall)
  );

  asc_frame_shift u_shift (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_cs_n      (sync_pins.cs_n),
    .i_sdi       (sync_pins.serial_command_in),
    .i_sclk_rise (sclk_rise),
    .i_sclk_fall (sclk_fall),
    .i_cs_fall   (cs_fall),
    .i_tx_word   (tx_word),
    .o_rx_word   (rx_word),
    .o_done      (frame_done),
    .o_sdo       (o_serial_result_out),
    .o_sdo_oe    (o_serial_result_oe)
  );

  // Field decode of the received frame
  assign frame_command_nibble =
    rx_word[asc_pkg::CMD_MSB:asc_pkg::CMD_LSB];
  assign lower_field_write_enable = rx_word[asc_pkg::WEN_BIT];
  assign last_channel_field =
    rx_word[asc_pkg::LAST_MSB:asc_pkg::LAST_LSB];
  assign rx_cfg.ctr_clear = rx_word[asc_pkg::CLR_BIT];
  assign rx_cfg.span      = rx_word[asc_pkg::SPAN_BIT];
  assign rx_cfg.sleep     = rx_word[asc_pkg::SLEEP_BIT];
  assign rx_cfg.fmt       = rx_word[asc_pkg::FMT_BIT];
  assign rx_cfg.gpio_lvl  =
    rx_word[asc_pkg::GPIO_MSB:asc_pkg::GPIO_LSB];

  assign is_auto2    = (frame_command_nibble == asc_pkg::CMD_AUTO2);
  assign is_depth    = (frame_command_nibble == asc_pkg::CMD_DEPTH);
  assign is_continue = (frame_command_nibble == asc_pkg::CMD_CONTINUE);
  assign cfg_write   = frame_done & is_auto2 & lower_field_write_enable;

  // Mode follows the scan code; other codes leave it as it was
  assign nxt_mode = (frame_done && is_auto2) ? asc_pkg::MODE_AUTO2
                                             : mode_ff;

  // depth frame skips span and GPIO
  assign nxt_cfg = cfg_write ? rx_cfg : cfg_ff;

  assign nxt_last_ch = (frame_done && is_depth) ? last_channel_field
                                                : last_ch_ff;

  // Channel to convert in the next frame
  always_comb begin
    nxt_chan = chan_ff;
    if (frame_done && (nxt_mode == asc_pkg::MODE_AUTO2)) begin
      // clear or step
      // Clear acts only in the frame that writes it
      if (cfg_write && rx_cfg.ctr_clear) begin
        nxt_chan = asc_pkg::CHAN_RST;
      end else begin
        nxt_chan = asc_pkg::next_channel(chan_ff, last_ch_ff);
      end
    end
  end

  always_comb begin
    nxt_sleep = sleep_ff;
    if (frame_done) begin
      nxt_sleep = nxt_cfg.sleep;
    end else if (cs_fall) begin
      nxt_sleep = 1'b0;
    end
  end

  // GPIO readback on top when the format bit is set
  // Previous conversion's channel pairs with its result
  assign top_nibble = cfg_ff.fmt ? sync_pins.gpio : conv_channel_ff;
  assign tx_word    = {top_nibble, i_conv_result};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_ff    <= asc_pkg::MODE_OTHER;
      cfg_ff     <= asc_pkg::CFG_RST;
      last_ch_ff <= asc_pkg::LAST_RST;
      chan_ff    <= asc_pkg::CHAN_RST;
      sleep_ff   <= 1'b0;
    end else begin
      mode_ff    <= nxt_mode;
      cfg_ff     <= nxt_cfg;
      last_ch_ff <= nxt_last_ch;
      chan_ff    <= nxt_chan;
      sleep_ff   <= nxt_sleep;
    end
  end

  // Conversion launch at frame start
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_start_ff   <= 1'b0;
      conv_channel_ff <= asc_pkg::CHAN_RST;
    end else begin
      conv_start_ff <= cs_fall;
      if (cs_fall) begin
        conv_channel_ff <= chan_ff;
      end
    end
  end

  assign o_conv_start        = conv_start_ff;
  assign o_conv_channel      = conv_channel_ff;
  assign o_input_span_select = cfg_ff.span;
  assign o_sleep             = sleep_ff;
  assign o_scan_mode_active  = (mode_ff == asc_pkg::MODE_AUTO2);
  assign o_last_channel      = last_ch_ff;

  assign o_gpio    = cfg_ff.gpio_lvl;
  assign o_gpio_oe = i_gpio_is_output;

  // Unused continue flag kept for readability of decode
  logic unused_continue;
  assign unused_continue = is_continue;

endmodule

// ==== verification/asc_sequencer_assertions.sv ====
// Purpose: Port checks for the depth-limited scan sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every asc_sequencer instance

`timescale 1ns/1ps

module asc_sequencer_assertions (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Inputs watched
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_gpio_is_output,
  // Outputs watched
  input  wire logic       o_serial_result_oe,
  input  wire logic [3:0] o_gpio_oe,
  input  wire logic [3:0] o_gpio,
  input  wire logic       o_conv_start,
  input  wire logic [3:0] o_conv_channel,
  input  wire logic       o_input_span_select,
  input  wire logic       o_sleep,
  input  wire logic [3:0] o_last_channel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  oe_on_a: assert property ($fell(i_cs_n) |-> ##[2:4] o_serial_result_oe)
    else $error("output enable late after select");
  oe_off_a: assert property ($rose(i_cs_n) |-> ##[2:4] !o_serial_result_oe)
    else $error("output enable held after deselect");
  start_cs_a: assert property ($fell(i_cs_n) |-> ##[2:4] o_conv_start)
    else $error("no conversion start in frame");
  start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start wider than one cycle");
  gpio_dir_a: assert property (o_gpio_oe == i_gpio_is_output)
    else $error("pin enable differs from direction");
  span_frame_a: assert property ($changed(o_input_span_select) |->
    !$past(i_cs_n, 5)) else $error("span changed outside frame");
  depth_frame_a: assert property ($changed(o_last_channel) |->
    !$past(i_cs_n, 5)) else $error("last channel changed outside frame");
  gpio_frame_a: assert property ($changed(o_gpio) |->
    !$past(i_cs_n, 5)) else $error("pin level changed outside frame");
  wrap_zero_a: assert property ($changed(o_conv_channel) &&
    $past(o_conv_channel) == $past(o_last_channel) |-> o_conv_channel == 4'h0)
    else $error("channel did not wrap to zero");
  step_one_a: assert property ($changed(o_conv_channel) &&
    o_conv_channel != 4'h0 |-> o_conv_channel == $past(o_conv_channel) + 4'h1)
    else $error("channel skipped a step");
  sleep_wake_a: assert property (o_sleep && $fell(i_cs_n) |->
    ##[2:6] !o_sleep) else $error("sleep not left on next frame");

  cover property ($rose(o_sleep));
  cover property ($changed(o_last_channel));
  cover property ($changed(o_conv_channel) && o_conv_channel == 4'h0);
endmodule

bind asc_sequencer asc_sequencer_assertions i_asc_sequencer_assertions (
  .i_clk, .i_nrst, .i_cs_n, .i_gpio_is_output, .o_serial_result_oe,
  .o_gpio_oe, .o_gpio, .o_conv_start, .o_conv_channel, .o_input_span_select,
  .o_sleep, .o_last_channel);

// ==== verification/asc_host_model.sv ====
// Purpose: Host serial master driving framed 16-bit transfers
// Assumes: Clock sits low outside frames
// Notes:   A short bit count cuts the frame to test dropping

`timescale 1ns/1ps

module asc_host_model (
  // Clock
  input  wire logic i_clk,
  // Serial link
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    // msb first, one bit per ten clocks
    for (int b = 15; b > 15 - nbits; b--) begin
      o_sdi <= tx[b];
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'b1;
      rx[b] = i_sdo;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released data line flips
    o_sdi  <= ~o_sdi;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: Frame-level tests of the scan sequencer
// Assumes: Host model drives clock, select and command pins; the result pin comes from the sequencer
// Notes:   Expected channel is tracked here, not read back

`timescale 1ns/1ps

module testbench;
  logic        i_clk;
  logic        i_nrst;
  logic        sclk, cs_n, serial_command_in, serial_result_out;
  logic [3:0]  i_gpio, gpio_dir, o_gpio, gpio_oe, chan, last;
  logic        span, sleep, mode;
  logic [11:0] result;
  logic [15:0] rx;
  int          failures, tests_run, cycles;

  asc_sequencer i_asc_sequencer (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_command_in(serial_command_in), .o_serial_result_out(serial_result_out),
    .o_serial_result_oe(), .i_gpio(i_gpio), .o_gpio(o_gpio),
    .o_gpio_oe(gpio_oe), .i_gpio_is_output(gpio_dir),
    .i_conv_result(result), .o_conv_start(), .o_conv_channel(chan),
    .o_input_span_select(span), .o_sleep(sleep),
    .o_scan_mode_active(mode), .o_last_channel(last));

  asc_host_model i_asc_host_model (
    .i_clk(i_clk), .i_sdo(serial_result_out), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_command_in));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [15:0] tx, input logic [3:0] top);
    result <= result + 12'h111;
    @(posedge i_clk);
    i_asc_host_model.xfer(tx, 16, rx);
    chk(rx, {top, result});
  endtask

  initial begin
    i_nrst = 1'b0;
    i_gpio = 4'h9;
    gpio_dir = 4'hf;
    result = 12'h0a5;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(16'(last), 16'h7);
    chk(16'({span, sleep, mode, o_gpio}), 16'h0);
    run(16'h3c4a, 4'h0);
    chk(16'({mode, span, o_gpio, chan}), 16'h03a0);
    run(16'h384a, 4'h0);
    chk(16'(chan), 16'h0);
    run(16'h9cbf, 4'h0);
    chk(16'({last, span, o_gpio, chan}), 16'h05a1);
    for (int i = 0; i < 4; i++) begin
      run(16'h0fff, 4'((i + 1) % 3));
      chk(16'({span, o_gpio, chan}), 16'({5'h1a, 4'((i + 2) % 3)}));
    end
    run(16'h37ff, 4'h2);
    chk(16'({span, o_gpio, chan}), 16'h1a0);
    gpio_dir <= 4'h3;
    run(16'h3c15, 4'h0);
    chk(16'({span, o_gpio & gpio_oe, chan}), 16'h011);
    run(16'h3c35, 4'h9);
    chk(16'({sleep, chan}), 16'h10);
    i_asc_host_model.xfer(16'h3c4a, 8, rx);
    chk(16'({sleep, span, o_gpio & gpio_oe, chan}), 16'h010);
    run(16'h0000, 4'h9);
    chk(16'(chan), 16'h0);
    test_done();
  end
endmodule
